// ---- pkg/fmsa_consts.svh ----
// Register offsets, instruction encodings and field positions of the multiply datapath
`ifndef FMSA_CONSTS_SVH
`define FMSA_CONSTS_SVH

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define OFF_INSTR 12'h000
`define OFF_STATUS 12'h004
`define OFF_SRCA_LO 12'h008
`define OFF_SRCA_HI 12'h00C
`define OFF_SRCB_LO 12'h010
`define OFF_SRCB_HI 12'h014
`define OFF_DSPCTL 12'h018
`define OFF_CFG 12'h01C
`define OFF_ACC_FIRST 12'h040
`define OFF_ACC_LAST 12'h07C

// ----------------------------------------------------------------
// Status and configuration bits, reset values
// ----------------------------------------------------------------
`define ST_BUSY 0
`define ST_RSV_ERR 1
`define ST_DIS_ERR 2
`define CFG_DSP_EN 0
`define RST_DSPCTL 32'h0000_0000
`define RST_DSP_EN 1'b1
`define FLAG_BASE 16

// ----------------------------------------------------------------
// Instruction fields and encodings
// ----------------------------------------------------------------
`define MAJOR_EXT 6'h1F
`define MAJOR_BASE 6'h00
`define MINOR_MSAQ 5'h06
`define MINOR_ZERO 5'h00
`define FN_PAIR 6'h30
`define FN_QUAD 6'h34
`define FN_MULS 6'h18
`define FN_MULU 6'h19
`define ZERO3 3'h0

// ----------------------------------------------------------------
// Q15 saturation values
// ----------------------------------------------------------------
`define Q15_MINUS_ONE 16'h8000
`define Q31_MAX 32'h7FFF_FFFF

`endif

// ---- pkg/fmsa_pkg.sv ----
// Types shared by the fractional multiply datapath modules
package fmsa_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PAIR,
    OP_QUAD,
    OP_MULS,
    OP_MULU
  } op_t;

  typedef struct packed {
    logic [3:0][63:0] acc_hi;
    logic [3:0][63:0] acc_lo;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [31:0] dsp_ctl;
    logic dsp_en;
    logic rsv_err;
    logic dis_err;
    logic [1:0] mul_ac;
    logic wb_pend;
    logic [31:0] prdata;
    logic slverr;
  } core_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [63:0] mcand;
    logic [31:0] mplier;
    logic [63:0] sum;
    logic [63:0] product;
  } mul_state_t;

endpackage

// ---- rtl/q15_product.sv ----
// Saturating Q15 x Q15 to Q31 product
`timescale 1ns/1ps
`include "fmsa_consts.svh"
module q15_product (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  output logic [31:0] prod,
  output logic saturated
);
  logic signed [31:0] raw;

  assign raw = $signed(a) * $signed(b);
  assign saturated = (a == `Q15_MINUS_ONE) && (b == `Q15_MINUS_ONE);
  // Only -1 x -1 can overflow the doubled product
  assign prod = saturated ? `Q31_MAX : {raw[30:0], 1'b0};
endmodule // q15_product

// ---- rtl/word_mul_seq.sv ----
// Background 32x32 shift-add multiplier with data-dependent latency
`timescale 1ns/1ps
module word_mul_seq import fmsa_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_signed,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output logic busy,
  output logic done,
  output logic [63:0] product
);
  mul_state_t st;
  mul_state_t nx;
  logic na;
  logic nb;
  logic [63:0] step_sum;

  always_comb begin
    nx = st;
    nx.done = 1'b0;
    na = is_signed & op_a[31];
    nb = is_signed & op_b[31];
    step_sum = st.mplier[0] ? st.sum + st.mcand : st.sum;
    if (start && !st.busy) begin
      nx.busy = 1'b1;
      nx.neg = na ^ nb;
      nx.mcand = {32'h0000_0000, na ? 32'h0000_0000 - op_a : op_a};
      nx.mplier = nb ? 32'h0000_0000 - op_b : op_b;
      nx.sum = 64'h0;
    end else if (st.busy) begin
      nx.sum = step_sum;
      nx.mcand = {st.mcand[62:0], 1'b0};
      nx.mplier = {1'b0, st.mplier[31:1]};
      // Stops once the multiplier runs out of ones: a short second operand ends early
      if (st.mplier[31:1] == 31'h0) begin // RULE20
        nx.busy = 1'b0;
        nx.done = 1'b1;
        nx.product = st.neg ? 64'h0 - step_sum : step_sum; // RULE13 RULE14
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign product = st.product;
endmodule // word_mul_seq

// ---- rtl/fmsa_core.sv ----
// Fractional multiply-subtract-accumulate and word multiply datapath with APB access
//
// Overview of operation
// RULE1: Pair variant: two doubled Q15 products
// RULE2: Pair: -1 times -1 gives 0x7FFFFFFF
// RULE3: Pair: upper minus lower, extended, accumulated
// RULE4: Pair: 64-bit low-word sum, halves sign-extended
// RULE5: Quad variant: four doubled Q15 products
// RULE6: Quad: -1 times -1 saturates product
// RULE7: Quad: alternate signs, plus highest first
// RULE8: Quad: extend to 128, add to HI:LO
// RULE9: Two-bit index picks one of four
// RULE10: Saturation sets control bit sixteen plus index
// RULE11: Only reserved and disabled exceptions
// RULE12: Quad opcode decode
// RULE13: Signed 32x32 gives 64-bit product
// RULE14: Unsigned 32x32 gives 64-bit product
// RULE15: Product halves sign-extended into HI, LO
// RULE16: Word multiply: no exception, no flag
// RULE17: Issuer supplies properly sign-extended word operands
// RULE18: HI/LO access stalls while multiply runs
// RULE19: Signed and unsigned word multiply decode
// RULE20: Shorter operand second finishes sooner
// RULE21: Pair opcode decode
// RULE22: Several saturations set one bit once
`timescale 1ns/1ps
`include "fmsa_consts.svh"
module fmsa_core import fmsa_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] sext32(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction

  function automatic logic in_acc(input logic [11:0] a);
    return (a >= `OFF_ACC_FIRST) && (a <= `OFF_ACC_LAST);
  endfunction

  // Lanes whose saturation counts for an operation
  function automatic logic [3:0] lane_mask(input op_t o);
    logic [3:0] m;
    m = 4'h0;
    case (o)
      OP_PAIR: begin
        m = 4'h3;
      end
      OP_QUAD: begin
        m = 4'hF;
      end
      default: begin
        m = 4'h0;
      end
    endcase
    return m;
  endfunction

  // One-hot flag of an accumulator, others untouched
  function automatic logic [31:0] flag_mask(input logic [1:0] a);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[`FLAG_BASE + a] = 1'b1;
    return m;
  endfunction

  function automatic op_t decode_op(input logic [31:0] iw);
    op_t op;
    op = OP_NONE;
    if (iw[15:13] == `ZERO3) begin
      if (iw[31:26] == `MAJOR_EXT && iw[10:6] == `MINOR_MSAQ) begin
        if (iw[5:0] == `FN_PAIR) begin
          op = OP_PAIR; // RULE21
        end else if (iw[5:0] == `FN_QUAD) begin
          op = OP_QUAD; // RULE12
        end
      end else if (iw[31:26] == `MAJOR_BASE && iw[10:6] == `MINOR_ZERO) begin
        if (iw[5:0] == `FN_MULS) begin
          op = OP_MULS; // RULE19
        end else if (iw[5:0] == `FN_MULU) begin
          op = OP_MULU; // RULE19
        end
      end
    end
    return op;
  endfunction

  // ----------------------------------------------------------------
  // State and datapath signals
  // ----------------------------------------------------------------
  core_state_t st;
  core_state_t nx;
  logic [3:0][31:0] prod;
  logic [3:0] sat;
  logic mul_busy;
  logic mul_done;
  logic [63:0] mul_product;
  logic mul_start;
  logic mul_signed;
  logic stall;
  logic wr_en;
  logic capture;
  logic mapped;
  logic [31:0] rd_word;
  op_t op;
  logic [1:0] ac;
  logic [63:0] pair_dotp;
  logic [63:0] pair_sum;
  logic [33:0] quad_dotp;
  logic [33:0] quad_upper;
  logic [33:0] quad_lower;
  logic [63:0] pair_hi_ext;
  logic [63:0] pair_lo_ext;
  logic [127:0] quad_sum;
  logic any_sat;
  logic rsv_set;
  logic dis_set;
  logic [1:0] aidx;

  // ----------------------------------------------------------------
  // Q15 products on the four halfword lanes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      q15_product u_prod (
        .a(st.src_a[16*g +: 16]),
        .b(st.src_b[16*g +: 16]),
        .prod(prod[g]),
        .saturated(sat[g])
      ); // RULE1 RULE2 RULE5 RULE6
    end
  endgenerate

  // ----------------------------------------------------------------
  // Background word multiplier
  // ----------------------------------------------------------------
  // Only the low words feed the multiplier; ill-formed upper bits are ignored
  word_mul_seq u_mul (
    .pclk(pclk),
    .presetn(presetn),
    .start(mul_start),
    .is_signed(mul_signed),
    .op_a(st.src_a[31:0]),
    .op_b(st.src_b[31:0]),
    .busy(mul_busy),
    .done(mul_done),
    .product(mul_product)
  ); // RULE17

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Covers the writeback cycle too, so a stalled read returns the new value
  assign stall = mul_busy | mul_done | st.wb_pend;
  assign pready = !(stall && (in_acc(paddr) || paddr == `OFF_INSTR)); // RULE18
  assign wr_en = psel & penable & pwrite & pready;
  assign capture = psel & !(penable & pready);
  assign prdata = st.prdata;
  assign pslverr = st.slverr;

  // ----------------------------------------------------------------
  // Instruction decode and arithmetic
  // ----------------------------------------------------------------
  assign op = decode_op(pwdata);
  assign ac = pwdata[12:11]; // RULE9
  assign aidx = paddr[5:4];

  // ----------------------------------------------------------------
  // Pair datapath
  // ----------------------------------------------------------------
  // Only low words take part; upper words rebuilt by extension
  always_comb begin
    pair_hi_ext = sext32(prod[1]);
    pair_lo_ext = sext32(prod[0]);
    pair_dotp = pair_hi_ext - pair_lo_ext; // RULE3
    pair_sum = {st.acc_hi[ac][31:0], st.acc_lo[ac][31:0]} + pair_dotp; // RULE4
  end

  // ----------------------------------------------------------------
  // Quad datapath
  // ----------------------------------------------------------------
  // 34 bits hold four full-scale products without wrap
  always_comb begin
    quad_upper = {{2{prod[3][31]}}, prod[3]} - {{2{prod[2][31]}}, prod[2]};
    quad_lower = {{2{prod[1][31]}}, prod[1]} - {{2{prod[0][31]}}, prod[0]};
    quad_dotp = quad_upper + quad_lower; // RULE7
    quad_sum = {st.acc_hi[ac], st.acc_lo[ac]} + {{94{quad_dotp[33]}}, quad_dotp}; // RULE8
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `OFF_INSTR) begin
      rd_word = 32'h0000_0000;
    end else if (paddr == `OFF_STATUS) begin
      rd_word[`ST_BUSY] = stall;
      rd_word[`ST_RSV_ERR] = st.rsv_err;
      rd_word[`ST_DIS_ERR] = st.dis_err;
    end else if (paddr == `OFF_SRCA_LO) begin
      rd_word = st.src_a[31:0];
    end else if (paddr == `OFF_SRCA_HI) begin
      rd_word = st.src_a[63:32];
    end else if (paddr == `OFF_SRCB_LO) begin
      rd_word = st.src_b[31:0];
    end else if (paddr == `OFF_SRCB_HI) begin
      rd_word = st.src_b[63:32];
    end else if (paddr == `OFF_DSPCTL) begin
      rd_word = st.dsp_ctl;
    end else if (paddr == `OFF_CFG) begin
      rd_word[`CFG_DSP_EN] = st.dsp_en;
    end else if (in_acc(paddr) && paddr[1:0] == 2'b00) begin
      if (paddr[3:2] == 2'd0) begin
        rd_word = st.acc_hi[aidx][31:0];
      end else if (paddr[3:2] == 2'd1) begin
        rd_word = st.acc_hi[aidx][63:32];
      end else if (paddr[3:2] == 2'd2) begin
        rd_word = st.acc_lo[aidx][31:0];
      end else begin
        rd_word = st.acc_lo[aidx][63:32];
      end
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nx = st;
    mul_start = 1'b0;
    mul_signed = 1'b0;
    any_sat = 1'b0;
    rsv_set = 1'b0;
    dis_set = 1'b0;
    nx.wb_pend = mul_done;

    if (capture) begin
      nx.prdata = rd_word;
      nx.slverr = !mapped;
    end

    if (wr_en) begin
      if (paddr == `OFF_INSTR) begin
        case (op)
          OP_PAIR: begin
            if (!st.dsp_en) begin
              dis_set = 1'b1;
            end else begin
              nx.acc_hi[ac] = sext32(pair_sum[63:32]); // RULE4
              nx.acc_lo[ac] = sext32(pair_sum[31:0]); // RULE4
              any_sat = |(sat & lane_mask(op));
            end
          end
          OP_QUAD: begin
            if (!st.dsp_en) begin
              dis_set = 1'b1;
            end else begin
              nx.acc_hi[ac] = quad_sum[127:64]; // RULE8
              nx.acc_lo[ac] = quad_sum[63:0]; // RULE8
              any_sat = |(sat & lane_mask(op));
            end
          end
          OP_MULS: begin
            mul_start = 1'b1;
            mul_signed = 1'b1; // RULE13
            nx.mul_ac = ac;
          end
          OP_MULU: begin
            mul_start = 1'b1;
            mul_signed = 1'b0; // RULE14
            nx.mul_ac = ac;
          end
          default: begin
            rsv_set = 1'b1; // RULE11
          end
        endcase
      end else if (paddr == `OFF_STATUS) begin
        nx.rsv_err = st.rsv_err & ~pwdata[`ST_RSV_ERR];
        nx.dis_err = st.dis_err & ~pwdata[`ST_DIS_ERR];
      end else if (paddr == `OFF_SRCA_LO) begin
        nx.src_a[31:0] = pwdata;
      end else if (paddr == `OFF_SRCA_HI) begin
        nx.src_a[63:32] = pwdata;
      end else if (paddr == `OFF_SRCB_LO) begin
        nx.src_b[31:0] = pwdata;
      end else if (paddr == `OFF_SRCB_HI) begin
        nx.src_b[63:32] = pwdata;
      end else if (paddr == `OFF_DSPCTL) begin
        nx.dsp_ctl = pwdata;
      end else if (paddr == `OFF_CFG) begin
        nx.dsp_en = pwdata[`CFG_DSP_EN];
      end else if (in_acc(paddr) && paddr[1:0] == 2'b00) begin
        if (paddr[3:2] == 2'd0) begin
          nx.acc_hi[aidx][31:0] = pwdata;
        end else if (paddr[3:2] == 2'd1) begin
          nx.acc_hi[aidx][63:32] = pwdata;
        end else if (paddr[3:2] == 2'd2) begin
          nx.acc_lo[aidx][31:0] = pwdata;
        end else begin
          nx.acc_lo[aidx][63:32] = pwdata;
        end
      end
    end

    // Word product writeback; never touches the control register
    if (mul_done) begin
      nx.acc_hi[st.mul_ac] = sext32(mul_product[63:32]); // RULE15 RULE16
      nx.acc_lo[st.mul_ac] = sext32(mul_product[31:0]); // RULE15
    end

    // Hardware sets applied last so they win over a clear
    if (any_sat) begin
      nx.dsp_ctl = nx.dsp_ctl | flag_mask(ac); // RULE10 RULE22
    end
    nx.rsv_err = nx.rsv_err | rsv_set; // RULE11
    nx.dis_err = nx.dis_err | dis_set; // RULE11
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.dsp_ctl <= `RST_DSPCTL;
      st.dsp_en <= `RST_DSP_EN;
    end else begin
      st <= nx;
    end
  end

endmodule // fmsa_core

// ---- tb/fmsa_checker.sv ----
// Bus-level assertions for the fractional multiply datapath
`timescale 1ns/1ps
`include "fmsa_consts.svh"
module fmsa_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] srcb;
  logic acc_sel, wr_done, mul_op, q15_op, fin;
  assign acc_sel = paddr >= `OFF_ACC_FIRST && paddr <= `OFF_ACC_LAST;
  assign fin = psel && penable && pready;
  assign wr_done = fin && pwrite;
  assign mul_op = pwdata[31:26] == `MAJOR_BASE && pwdata[5:1] == 5'h0C;
  assign q15_op = pwdata[31:26] == `MAJOR_EXT && pwdata[10:6] == `MINOR_MSAQ
    && pwdata[15:13] == `ZERO3 && (pwdata[5:0] == `FN_PAIR || pwdata[5:0] == `FN_QUAD);
  // Multiplier operand kept so the stall check only fires when the second operand is 2 or 3, a count of exactly two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srcb <= 32'h0000_0000;
    end else if (wr_done && paddr == `OFF_SRCB_LO) begin
      srcb <= pwdata;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence mul_launch;
    wr_done && paddr == `OFF_INSTR && mul_op && srcb[31:1] == 31'h1;
  endsequence
  sequence acc_setup;
    psel && !penable && acc_sel;
  endsequence
  a_mul_stalls: assert property (mul_launch ##2 acc_setup |=> !pready)
    else $error("accumulator access not held during word multiply");
  a_q15_no_stall: assert property (wr_done && paddr == `OFF_INSTR && q15_op |=> pready[*3])
    else $error("Q15 operation started a stall");
  a_stall_bounded: assert property (psel && penable && !pready |-> ##[1:40] pready)
    else $error("stall too long");
  a_stall_where: assert property (psel && !pready |-> acc_sel || paddr == `OFF_INSTR)
    else $error("stall on a register that never waits");
  a_status_no_wait: assert property (psel && penable && paddr == `OFF_STATUS |-> pready)
    else $error("status access stalled");
  a_unmapped_err: assert property (fin && paddr >= 12'h020 && paddr < `OFF_ACC_FIRST
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (fin && paddr < 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_instr_reads_zero: assert property (fin && !pwrite && paddr == `OFF_INSTR
    |-> prdata == 32'h0000_0000)
    else $error("instruction register read nonzero");
endmodule // fmsa_checker

bind fmsa_core fmsa_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ---- tb/pipe_model.sv ----
// Issuing-pipeline model: APB master that feeds operands and instructions
`timescale 1ns/1ps
module pipe_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Released lines show the inverse so a stale value never looks valid
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
  task word_src(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, v, q, e);
    xfer(1'b1, a + 12'h004, {32{v[31]}}, q, e);
  endtask
endmodule // pipe_model

// ---- tb/tb.sv ----
// Self-checking bench for the fractional multiply datapath
`timescale 1ns/1ps
`include "fmsa_consts.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  initial begin
    forever #5 pclk = ~pclk;
  end
  fmsa_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pipe_model pipe (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task print_verdict;
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  task chk(input string n, input logic [127:0] x, input logic [127:0] g);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    pipe.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    pipe.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  function logic [11:0] acc_at(input logic [1:0] n, input logic [1:0] w);
    return `OFF_ACC_FIRST + 12'({n, w, 2'b00});
  endfunction
  // Word slots of {HI, LO}: HI low word sits at offset 0
  task rd_acc(input logic [1:0] n, output logic [127:0] v);
    for (int w = 0; w < 4; w++) begin
      rd(acc_at(n, 2'(w)), q);
      v[32 * (w ^ 2) +: 32] = q;
    end
  endtask
  task wr_acc(input logic [1:0] n, input logic [127:0] v);
    for (int w = 0; w < 4; w++) wr(acc_at(n, 2'(w)), v[32 * (w ^ 2) +: 32]);
  endtask
  function logic [31:0] ins(input logic [5:0] mj, input logic [1:0] ac, input logic [5:0] fn,
    input logic [4:0] mn);
    return {mj, 10'h000, `ZERO3, ac, mn, fn};
  endfunction
  function automatic logic [31:0] q15(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == `Q15_MINUS_ONE && b == `Q15_MINUS_ONE) begin
      hit = 1'b1;
      return `Q31_MAX;
    end
    return p << 1;
  endfunction
  task t_regs;
    rd(`OFF_DSPCTL, q);
    chk("dspctl reset", `RST_DSPCTL, q);
    rd(`OFF_CFG, q);
    chk("cfg reset", `RST_DSP_EN, q);
    rd(`OFF_INSTR, q);
    chk("instr read", 0, q);
    rd(12'h020, q);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
  endtask
  task t_pair(input logic [1:0] ac, input logic [31:0] a, input logic [31:0] b,
    input logic [127:0] v0);
    logic [127:0] v;
    logic [63:0] s;
    logic [31:0] f, pa, pb;
    rd(`OFF_DSPCTL, f);
    wr_acc(ac, v0);
    wr(`OFF_SRCA_LO, a);
    wr(`OFF_SRCB_LO, b);
    wr(`OFF_INSTR, ins(`MAJOR_EXT, ac, `FN_PAIR, `MINOR_MSAQ));
    hit = 1'b0;
    pb = q15(a[31:16], b[31:16]);
    pa = q15(a[15:0], b[15:0]);
    s = {v0[95:64], v0[31:0]} + {{32{pb[31]}}, pb} - {{32{pa[31]}}, pa};
    if (hit) f[`FLAG_BASE + ac] = 1'b1;
    rd_acc(ac, v);
    chk("pair acc", {{32{s[63]}}, s[63:32], {32{s[31]}}, s[31:0]}, v);
    rd(`OFF_DSPCTL, q);
    chk("pair flags", f, q);
  endtask
  task t_quad(input logic [1:0] ac, input logic [63:0] a, input logic [63:0] b,
    input logic [127:0] v0);
    logic [127:0] v, s;
    logic [31:0] f, p;
    rd(`OFF_DSPCTL, f);
    wr_acc(ac, v0);
    for (int i = 0; i < 2; i++) wr(`OFF_SRCA_LO + 12'(4 * i), a[32 * i +: 32]);
    for (int i = 0; i < 2; i++) wr(`OFF_SRCB_LO + 12'(4 * i), b[32 * i +: 32]);
    wr(`OFF_INSTR, ins(`MAJOR_EXT, ac, `FN_QUAD, `MINOR_MSAQ));
    hit = 1'b0;
    s = v0;
    for (int i = 0; i < 4; i++) begin
      p = q15(a[16 * i +: 16], b[16 * i +: 16]);
      if (i % 2 == 1) s = s + {{96{p[31]}}, p};
      else s = s - {{96{p[31]}}, p};
    end
    if (hit) f[`FLAG_BASE + ac] = 1'b1;
    rd_acc(ac, v);
    chk("quad acc", s, v);
    rd(`OFF_DSPCTL, q);
    chk("quad flags", f, q);
  endtask
  task t_word;
    logic [127:0] v;
    logic signed [63:0] p;
    logic [31:0] f, la, lb;
    la = 32'hFFFF_FFFE;
    lb = 32'h0000_0003;
    rd(`OFF_DSPCTL, f);
    pipe.word_src(`OFF_SRCA_LO, la);
    pipe.word_src(`OFF_SRCB_LO, lb);
    for (int u = 0; u < 2; u++) begin
      wr(`OFF_INSTR, ins(`MAJOR_BASE, 2'(2 * u), u ? `FN_MULU : `FN_MULS, `MINOR_ZERO));
      rd_acc(2'(2 * u), v);
      if (u == 1) p = {32'h0, la} * {32'h0, lb};
      else p = $signed(la) * $signed(lb);
      chk("word acc", {{32{p[63]}}, p[63:32], {32{p[31]}}, p[31:0]}, v);
    end
    rd(`OFF_DSPCTL, q);
    chk("word flags", f, q);
    rd(`OFF_STATUS, q);
    chk("word status", 0, q);
  endtask
  task t_refuse;
    logic [127:0] v0, v;
    rd_acc(2'd1, v0);
    wr(`OFF_INSTR, ins(`MAJOR_EXT, 2'd1, `FN_PAIR, `MINOR_MSAQ) | 32'h0000_2000);
    rd(`OFF_STATUS, q);
    chk("reserved", 32'h0000_0002, q);
    wr(`OFF_STATUS, 32'h0000_0007);
    wr(`OFF_CFG, 32'h0000_0000);
    wr(`OFF_INSTR, ins(`MAJOR_EXT, 2'd1, `FN_PAIR, `MINOR_MSAQ));
    rd(`OFF_STATUS, q);
    chk("disabled", 32'h0000_0004, q);
    rd_acc(2'd1, v);
    chk("no update", v0, v);
    wr(`OFF_STATUS, 32'h0000_0007);
    wr(`OFF_CFG, 32'h0000_0001);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_pair(2'd1, 32'h8000_4000, 32'h8000_2000, {32'h1234_5678, 32'h1, 32'h9ABC_DEF0, 32'hFFFF_FFF0});
    t_pair(2'd0, 32'h7FFF_8001, 32'h8000_7FFF, 128'h0);
    t_quad(2'd3, 64'h8000_4000_8000_0001, 64'h8000_C000_8000_7FFF, {64'h0, {64{1'b1}}});
    t_word;
    t_refuse;
    print_verdict;
  end
endmodule // tb
